// [lcdt_timing.sv]
// LCD drive mode, frame timing and output level selection with AHB-Lite registers.
//
// Overview of operation
// R1 - Reset: all outputs at supply level, display off.
// R2 - Reset default: four backplanes, one-third bias.
// R3 - Reset clears blink, bank selects, command interface.
// R4 - Reset clears data pointer and subaddress counter.
// R5 - Host waits one millisecond after power-on.
// R6 - Half bias shorts middle divider element.
// R7 - Levels follow last written drive configuration.
// R8 - Static, two, three, four backplane multiplexing.
// R9 - Two backplanes: half or third bias.
// R10 - Three, four backplanes also accept half bias.
// R11 - Strap picks internal oscillator or clock pin.
// R12 - Frame signal is selected clock over 24.
// R13 - External clock must run continuously.
// R14 - Display memory latched to segments per frame.
// R15 - Unused backplanes mirror their paired backplane.
// R16 - Memory rows map to backplanes, columns segments.
// R17 - Dividers restart at reset, phase steps per frame.
`timescale 1ns/1ps

module lcdt_timing #(
   parameter int POR_CYCLES = lcdt_pkg::POR_CYCLES,
   parameter int INT_OSC_DIV = lcdt_pkg::INT_OSC_DIV,
   parameter int NUM_SEG = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Pins
   input wire logic clock_source_strap,
   input wire logic ext_clk_pin,
   // LCD drive
   output logic [3:0][1:0] backplane_outputs,
   output logic [NUM_SEG-1:0][1:0] segment_outputs,
   output logic bias_bypass,
   output logic frame_pulse
);

   // -------------------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------------------
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_val;
   logic addr_ok;
   lcdt_pkg::lcdt_ctrl_t ctrl_r;
   logic [4:0] ptr_r;
   logic [2:0] sub_r;
   logic [1:0] phase_r;
   logic pol_r;
   logic [1:0] strap_sync_r;
   logic [15:0] por_cnt_r;
   logic por_ready;
   logic bypass_r;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign addr_ok = hsel && hready && (htrans == lcdt_pkg::HTRANS_NONSEQ);
   assign por_ready = (por_cnt_r == 16'(POR_CYCLES));

   always_comb begin
      rd_val = 32'h0000_0000;
      case (haddr[7:0])
         lcdt_pkg::ADDR_CTRL: begin
            rd_val[lcdt_pkg::CTRL_W-1:0] = ctrl_r;
         end
         lcdt_pkg::ADDR_PTR: begin
            rd_val[4:0] = ptr_r;
            rd_val[lcdt_pkg::PTR_SUB_LO +: 3] = sub_r;
         end
         lcdt_pkg::ADDR_STATUS: begin
            rd_val[lcdt_pkg::ST_PHASE_LO +: 2] = phase_r;
            rd_val[lcdt_pkg::ST_POL] = pol_r;
            rd_val[lcdt_pkg::ST_STRAP] = strap_sync_r[1];
            rd_val[lcdt_pkg::ST_BYPASS] = bypass_r;
            rd_val[lcdt_pkg::ST_READY] = por_ready;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // Address phase captured; write data applied in the following data phase.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_pend_r <= 1'b0; // R3
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         wr_addr_r <= haddr[7:0];
         if (addr_ok && !hwrite) begin
            hrdata_r <= rd_val;
         end
      end
   end

   // Power-on settle counter, shown as ready in status once the host may talk.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         por_cnt_r <= 16'h0000; // R5
      end else if (!por_ready) begin
         por_cnt_r <= por_cnt_r + 16'h0001;
      end
   end

   // -------------------------------------------------------------------------
   // Configuration and display memory
   // -------------------------------------------------------------------------
   logic wr_ctrl;
   logic wr_ptr;
   logic wr_data;
   logic [lcdt_pkg::DATA_W-1:0] ram_r [0:NUM_SEG-1];

   assign wr_ctrl = wr_pend_r && (wr_addr_r == lcdt_pkg::ADDR_CTRL);
   assign wr_ptr = wr_pend_r && (wr_addr_r == lcdt_pkg::ADDR_PTR);
   assign wr_data = wr_pend_r && (wr_addr_r == lcdt_pkg::ADDR_DATA);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_r <= lcdt_pkg::CTRL_RESET; // R1 R2 R3
      end else if (wr_ctrl) begin
         ctrl_r <= hwdata[lcdt_pkg::CTRL_W-1:0]; // R7 R8 R9 R10
      end
   end

   // Each data write stores one column and advances across subaddress boundaries.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ptr_r <= 5'h00; // R4
         sub_r <= 3'h0; // R4
      end else if (wr_ptr) begin
         ptr_r <= hwdata[4:0];
         sub_r <= hwdata[lcdt_pkg::PTR_SUB_LO +: 3];
      end else if (wr_data) begin
         ptr_r <= ptr_r + 5'h01;
         if (ptr_r == 5'h1F) begin
            sub_r <= sub_r + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_data) begin
         ram_r[ptr_r] <= hwdata[lcdt_pkg::DATA_W-1:0]; // R16
      end
   end

   // -------------------------------------------------------------------------
   // Clock source selection and frame divider
   // -------------------------------------------------------------------------
   logic [1:0] ext_sync_r;
   logic ext_prev_r;
   logic [7:0] osc_cnt_r;
   logic osc_tick;
   logic ext_tick;
   logic sel_tick;
   logic [4:0] fdiv_cnt_r;
   logic frame_step;
   logic [1:0] last_phase;

   always_ff @(posedge core_clk) begin
      strap_sync_r <= {strap_sync_r[0], clock_source_strap};
      ext_sync_r <= {ext_sync_r[0], ext_clk_pin};
      ext_prev_r <= ext_sync_r[1];
   end

   assign osc_tick = (osc_cnt_r == 8'(INT_OSC_DIV - 1));
   assign ext_tick = ext_sync_r[1] && !ext_prev_r;
   assign sel_tick = strap_sync_r[1] ? ext_tick : osc_tick; // R11 R13
   assign frame_step = sel_tick && (fdiv_cnt_r == lcdt_pkg::FRAME_DIV - 5'h01);

   always_ff @(posedge core_clk) begin
      if (reset || osc_tick) begin
         osc_cnt_r <= 8'h00; // R17
      end else begin
         osc_cnt_r <= osc_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         fdiv_cnt_r <= 5'h00; // R17
      end else if (frame_step) begin
         fdiv_cnt_r <= 5'h00; // R12
      end else if (sel_tick) begin
         fdiv_cnt_r <= fdiv_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         frame_pulse <= 1'b0;
      end else begin
         frame_pulse <= frame_step; // R12
      end
   end

   always_comb begin
      case (ctrl_r.mux)
         lcdt_pkg::MUX_STATIC: last_phase = 2'h0;
         lcdt_pkg::MUX_2: last_phase = 2'h1;
         lcdt_pkg::MUX_3: last_phase = 2'h2;
         default: last_phase = 2'h3;
      endcase
   end

   // One backplane phase per frame step; polarity flips after the last phase.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         phase_r <= 2'h0; // R17
         pol_r <= 1'b0;
      end else if (frame_step) begin
         if (phase_r >= last_phase) begin
            phase_r <= 2'h0; // R17
            pol_r <= !pol_r;
         end else begin
            phase_r <= phase_r + 2'h1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Display latch
   // -------------------------------------------------------------------------
   logic [3:0][NUM_SEG-1:0] latch_r;
   logic latch_load;

   assign latch_load = frame_step && (phase_r >= last_phase);

   genvar gc;
   generate
      for (gc = 0; gc < NUM_SEG; gc++) begin : g_latch
         always_ff @(posedge core_clk) begin
            if (reset) begin
               latch_r[0][gc] <= 1'b0;
               latch_r[1][gc] <= 1'b0;
               latch_r[2][gc] <= 1'b0;
               latch_r[3][gc] <= 1'b0;
            end else if (latch_load) begin
               latch_r[0][gc] <= ram_r[gc][0]; // R14 R16
               latch_r[1][gc] <= ram_r[gc][1];
               latch_r[2][gc] <= ram_r[gc][2];
               latch_r[3][gc] <= ram_r[gc][3];
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Level selection
   // -------------------------------------------------------------------------
   logic [1:0] cur_row;
   logic [1:0] lvl_act;
   logic [1:0] lvl_idle_bp;
   logic [1:0] lvl_on;
   logic [1:0] lvl_off;
   logic is_static;

   assign is_static = (ctrl_r.mux == lcdt_pkg::MUX_STATIC);

   // Static and two-backplane modes read the bank chosen by the output bank select.
   always_comb begin
      case (ctrl_r.mux)
         lcdt_pkg::MUX_STATIC: cur_row = {ctrl_r.out_bank, 1'b0};
         lcdt_pkg::MUX_2: cur_row = {ctrl_r.out_bank, phase_r[0]};
         default: cur_row = phase_r; // R16
      endcase
   end

   always_comb begin
      lvl_act = pol_r ? lcdt_pkg::LVL_VSS : lcdt_pkg::LVL_LCD;
      lvl_on = pol_r ? lcdt_pkg::LVL_LCD : lcdt_pkg::LVL_VSS;
      if (is_static) begin
         lvl_idle_bp = lvl_act;
         lvl_off = lvl_act;
      end else if (ctrl_r.half_bias) begin
         lvl_idle_bp = lcdt_pkg::LVL_LO; // R9 R10
         lvl_off = lcdt_pkg::LVL_LO;
      end else begin
         lvl_idle_bp = pol_r ? lcdt_pkg::LVL_HI : lcdt_pkg::LVL_LO; // R9
         lvl_off = pol_r ? lcdt_pkg::LVL_LO : lcdt_pkg::LVL_HI;
      end
   end

   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_bp
         logic [1:0] bp_row;
         always_comb begin
            case (ctrl_r.mux)
               lcdt_pkg::MUX_STATIC: bp_row = cur_row; // R15
               lcdt_pkg::MUX_2: bp_row = {ctrl_r.out_bank, 1'(gb % 2)}; // R15
               lcdt_pkg::MUX_3: bp_row = (gb == 3) ? 2'h1 : 2'(gb); // R15
               default: bp_row = 2'(gb);
            endcase
         end
         always_ff @(posedge core_clk) begin
            if (reset || !ctrl_r.display_en) begin
               backplane_outputs[gb] <= lcdt_pkg::LVL_LCD; // R1
            end else if (bp_row == cur_row) begin
               backplane_outputs[gb] <= lvl_act; // R7
            end else begin
               backplane_outputs[gb] <= lvl_idle_bp; // R7
            end
         end
      end
   endgenerate

   genvar gs;
   generate
      for (gs = 0; gs < NUM_SEG; gs++) begin : g_seg
         always_ff @(posedge core_clk) begin
            if (reset || !ctrl_r.display_en) begin
               segment_outputs[gs] <= lcdt_pkg::LVL_LCD; // R1
            end else if (latch_r[cur_row][gs]) begin
               segment_outputs[gs] <= lvl_on; // R7 R16
            end else begin
               segment_outputs[gs] <= lvl_off; // R7
            end
         end
      end
   endgenerate

   // Half bias shorts the centre impedance of the divider in every multiplexed mode.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bypass_r <= 1'b0;
      end else begin
         bypass_r <= ctrl_r.half_bias && !is_static; // R6 R10
      end
   end

   assign bias_bypass = bypass_r;

endmodule

// [lcdt_pkg.sv]
// Package with constants and types of the LCD drive and mode timing block.
package lcdt_pkg;

   // -------------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PTR = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;

   // -------------------------------------------------------------------------
   // Multiplex codes and drive levels
   // -------------------------------------------------------------------------
   localparam logic [1:0] MUX_4 = 2'h0;
   localparam logic [1:0] MUX_STATIC = 2'h1;
   localparam logic [1:0] MUX_2 = 2'h2;
   localparam logic [1:0] MUX_3 = 2'h3;

   localparam logic [1:0] LVL_VSS = 2'h0;
   localparam logic [1:0] LVL_LO = 2'h1;
   localparam logic [1:0] LVL_HI = 2'h2;
   localparam logic [1:0] LVL_LCD = 2'h3;

   // -------------------------------------------------------------------------
   // Control word carried as one struct
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic out_bank;
      logic in_bank;
      logic blink_en;
      logic display_en;
      logic half_bias;
      logic [1:0] mux;
   } lcdt_ctrl_t;

   localparam int CTRL_W = 7;
   localparam lcdt_ctrl_t CTRL_RESET = '{out_bank: 1'b0, in_bank: 1'b0, blink_en: 1'b0,
                                         display_en: 1'b0, half_bias: 1'b0, mux: MUX_4};

   // Status bit positions.
   localparam int ST_PHASE_LO = 0;
   localparam int ST_POL = 2;
   localparam int ST_STRAP = 3;
   localparam int ST_BYPASS = 4;
   localparam int ST_READY = 5;
   // Pointer register fields.
   localparam int PTR_SUB_LO = 8;
   localparam int DATA_W = 4;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int POR_WAIT_MS = 1;
   localparam int POR_CYCLES = CLK_HZ / 1000 * POR_WAIT_MS;
   localparam logic [4:0] FRAME_DIV = 5'h18;
   localparam int INT_OSC_DIV = 10;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// [lcdt_props.sv]
// Checker of the LCD timing block outputs against its inputs.
`timescale 1ns/1ps
module lcdt_props #(
   parameter int INT_OSC_DIV = 2
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   // Pins and drive
   input wire logic clock_source_strap,
   input wire logic [3:0][1:0] backplane_outputs,
   input wire logic [31:0][1:0] segment_outputs,
   input wire logic bias_bypass,
   input wire logic frame_pulse
);
   // --------------------
   // Shadow of control
   // --------------------
   logic wp_r;
   logic [1:0] mx_r;
   logic hb_r;
   logic de_r;
   logic [3:0] st_r;
   logic [7:0] gp_r;
   logic vd_r;
   logic ok;
   logic [3:0][1:0] bp;
   assign ok = st_r > 4'h2;
   assign bp = backplane_outputs;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wp_r <= 1'b0;
         mx_r <= 2'h0;
         hb_r <= 1'b0;
         de_r <= 1'b0;
         st_r <= 4'h0;
      end else begin
         wp_r <= hsel && hready && htrans == 2'h2 && hwrite && haddr[7:0] == 8'h00;
         if (wp_r) begin
            mx_r <= hwdata[1:0];
            hb_r <= hwdata[2];
            de_r <= hwdata[3];
            st_r <= 4'h0;
         end else if (st_r != 4'hF) begin
            st_r <= st_r + 4'h1;
         end
      end
   end
   // Only intervals between two pulses of the internal source are judged.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         gp_r <= 8'h00;
         vd_r <= 1'b0;
      end else if (frame_pulse) begin
         gp_r <= 8'h00;
         vd_r <= !clock_source_strap;
      end else begin
         gp_r <= gp_r + 8'h01;
      end
   end
   property p_rst_bp;
      disable iff (1'b0) reset |=> bp == 8'hFF;
   endproperty
   a_rst_bp: assert property (p_rst_bp) else $error("backplane not at supply");
   property p_rst_out;
      disable iff (1'b0) reset ##1 reset |-> &segment_outputs && !frame_pulse && !bias_bypass;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs wrong in reset");
   property p_off;
      ok && !de_r |-> bp == 8'hFF && &segment_outputs;
   endproperty
   a_off: assert property (p_off) else $error("display not blank");
   property p_pulse;
      frame_pulse |=> !frame_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("frame pulse too long");
   property p_frame;
      frame_pulse && vd_r && !clock_source_strap |-> gp_r == 24 * INT_OSC_DIV - 1;
   endproperty
   a_frame: assert property (p_frame) else $error("frame period wrong");
   property p_static;
      ok && mx_r == lcdt_pkg::MUX_STATIC |-> bp[0] == bp[1] && bp[1] == bp[2] && bp[2] == bp[3];
   endproperty
   a_static: assert property (p_static) else $error("static backplanes differ");
   property p_mux2;
      ok && mx_r == lcdt_pkg::MUX_2 |-> bp[0] == bp[2] && bp[1] == bp[3];
   endproperty
   a_mux2: assert property (p_mux2) else $error("duplex pairs differ");
   property p_mux3;
      ok && mx_r == lcdt_pkg::MUX_3 |-> bp[3] == bp[1];
   endproperty
   a_mux3: assert property (p_mux3) else $error("third mode pair differs");
   property p_bypass;
      ok |-> bias_bypass == (hb_r && mx_r != lcdt_pkg::MUX_STATIC);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass switch wrong");
   // Half bias has three levels, so no backplane may sit on the upper tap.
   property p_half;
      ok && de_r && hb_r && mx_r != lcdt_pkg::MUX_STATIC |->
         bp[0] != lcdt_pkg::LVL_HI && bp[1] != lcdt_pkg::LVL_HI &&
         bp[2] != lcdt_pkg::LVL_HI && bp[3] != lcdt_pkg::LVL_HI;
   endproperty
   a_half: assert property (p_half) else $error("half bias uses upper tap");
   c_frame: cover property (frame_pulse && vd_r);
   c_mux2: cover property (ok && de_r && mx_r == lcdt_pkg::MUX_2);
   c_bypass: cover property (bias_bypass);
endmodule

// [lcdt_panel.sv]
// Panel model that counts lit cycles of the elements on segment zero.
`timescale 1ns/1ps
module lcdt_panel (
   // Clock and control
   input wire logic core_clk,
   input wire logic clr,
   // Drive levels
   input wire logic [3:0][1:0] bp,
   input wire logic [1:0] seg,
   // Activity
   output logic [3:0][15:0] on_cnt
);
   // --------------------
   // Elements
   // --------------------
   // An element lights only when it sees the full supply swing.
   always_ff @(posedge core_clk) begin
      for (int k = 0; k < 4; k++) begin
         if (clr) begin
            on_cnt[k] <= 16'h0;
         end else if ((bp[k] == 2'h3 && seg == 2'h0) || (bp[k] == 2'h0 && seg == 2'h3)) begin
            on_cnt[k] <= on_cnt[k] + 16'h1;
         end
      end
   end
endmodule

// [tb.sv]
// Testbench of the LCD timing block.
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic strap = 1'b0;
   logic ext = 1'b0;
   logic clr = 1'b1;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [3:0][1:0] bp;
   logic [31:0][1:0] seg;
   logic bb;
   logic fp;
   logic [3:0][15:0] on_cnt;
   logic [31:0] rv;
   int miscompares = 0;
   int total_checks = 0;
   int n;
   lcdt_timing #(.POR_CYCLES(20), .INT_OSC_DIV(2)) uut (
      .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .clock_source_strap(strap), .ext_clk_pin(ext),
      .backplane_outputs(bp), .segment_outputs(seg), .bias_bypass(bb), .frame_pulse(fp));
   lcdt_panel u_panel (.core_clk(core_clk), .clr(clr), .bp(bp), .seg(seg[0]), .on_cnt(on_cnt));
   // --------------------
   // Tasks
   // --------------------
   initial forever #50 core_clk = ~core_clk;
   // The external clock never stops, so the panel never sees a frozen drive.
   always #300 ext = ~ext;
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      htrans <= lcdt_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   task automatic gap(input int e);
      @(posedge core_clk iff fp === 1'b1);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (fp !== 1'b1);
      chk("frame gap", n, e);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      miscompares++;
      final_report;
   end
   initial begin
      wt(12);
      reset <= 1'b0;
      chk("bp reset", bp, 32'h0000_00FF);
      chk("seg reset", &seg, 1);
      wt(20);
      bus(0, lcdt_pkg::ADDR_STATUS, 0);
      chk("ready", rv[5], 1);
      chk("strap low", rv[3], 0);
      chk("phase reset", rv[2:0], 0);
      chk("okay resp", hresp, 0);
      bus(0, lcdt_pkg::ADDR_CTRL, 0);
      chk("ctrl reset", rv, 0);
      bus(0, lcdt_pkg::ADDR_PTR, 0);
      chk("ptr reset", rv, 0);
      bus(0, 8'h10, 0);
      chk("unmapped", rv, 0);
      gap(48);
      bus(1, lcdt_pkg::ADDR_PTR, 32'h0000_001F);
      bus(1, lcdt_pkg::ADDR_DATA, 0);
      bus(0, lcdt_pkg::ADDR_PTR, 0);
      chk("ptr wrap", rv, 32'h0000_0100);
      bus(1, lcdt_pkg::ADDR_PTR, 0);
      bus(1, lcdt_pkg::ADDR_DATA, 32'h0000_0001);
      for (int m = 0; m < 8; m++) begin
         bus(1, lcdt_pkg::ADDR_CTRL, m + 8);
         clr <= 1'b1;
         wt(250);
         clr <= 1'b0;
         wt(250);
         chk("row0 lit", on_cnt[0] != 0, 1);
         chk("row1 dark", on_cnt[1] == 0, m[1:0] != lcdt_pkg::MUX_STATIC);
         chk("bypass pin", bb, m[2] && m[1:0] != lcdt_pkg::MUX_STATIC);
         bus(0, lcdt_pkg::ADDR_STATUS, 0);
         chk("bypass bit", rv[4], m[2] && m[1:0] != lcdt_pkg::MUX_STATIC);
      end
      // Static mode on the other output bank shows row two, which is dark in column zero.
      bus(1, lcdt_pkg::ADDR_CTRL, 32'h0000_0079);
      bus(0, lcdt_pkg::ADDR_CTRL, 0);
      chk("ctrl readback", rv, 32'h0000_0079);
      clr <= 1'b1;
      wt(250);
      clr <= 1'b0;
      wt(250);
      chk("bank dark", on_cnt[0], 0);
      strap <= 1'b1;
      wt(10);
      gap(144);
      bus(0, lcdt_pkg::ADDR_STATUS, 0);
      chk("strap high", rv[3], 1);
      final_report;
   end
endmodule
bind lcdt_timing lcdt_props #(.INT_OSC_DIV(INT_OSC_DIV)) u_props (.core_clk, .reset, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hwdata, .clock_source_strap, .backplane_outputs,
   .segment_outputs, .bias_bypass, .frame_pulse);
